// *** afm_link_model.sv ***
`timescale 1ns/10ps
module afm_link_model (
    output reg link_clk,
    output reg link_sync,
    output reg link_dat
);
    integer i;
    initial begin
        link_clk = 1'h0;
        link_sync = 1'h0;
        link_dat = 1'h0;
    end
    // The clock stands still between words; released data flips so stale bits never look valid.
    task send(input [15:0] w);
        #33 link_sync = 1'h1;
        for (i = 15; i >= 0; i = i - 1) begin
            link_dat = w[i];
            #80 link_clk = 1'h1;
            #80 link_clk = 1'h0;
        end
        #80 link_sync = 1'h0;
        link_dat = ~link_dat;
    endtask
endmodule // afm_link_model

// *** afm_link_rx.v ***
`timescale 1ns/10ps
`include "afm_regs.vh"
module afm_link_rx (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        link_clk,
    input  wire        link_sync,
    input  wire        link_dat,
    output reg         word_valid_r,
    output reg  [15:0] word_r
);
    reg [2:0]  clk_s_r;
    reg [1:0]  sync_s_r;
    reg [1:0]  dat_s_r;
    reg [15:0] shift_r;
    reg [4:0]  nbits_r;
    reg        in_word_r;
    wire       rise;

    // Only the second stage and the edge history flop are looked at.
    assign rise = clk_s_r[1] & ~clk_s_r[2];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_s_r      <= 3'h0;
            sync_s_r     <= 2'h0;
            dat_s_r      <= 2'h0;
            shift_r      <= 16'h0000;
            nbits_r      <= 5'h00;
            in_word_r    <= 1'b0;
            word_valid_r <= 1'b0;
            word_r       <= 16'h0000;
        end else begin
            clk_s_r      <= {clk_s_r[1:0], link_clk};
            sync_s_r     <= {sync_s_r[0], link_sync};
            dat_s_r      <= {dat_s_r[0], link_dat};
            word_valid_r <= 1'b0;
            in_word_r    <= sync_s_r[1];
            if (sync_s_r[1] && !in_word_r) begin
                nbits_r <= 5'h00;
            end else if (sync_s_r[1] && rise) begin
                shift_r <= {shift_r[14:0], dat_s_r[1]};
                nbits_r <= nbits_r + 5'h01;
            end
            // A word cut short by the strobe is dropped whole.
            if (!sync_s_r[1] && in_word_r && nbits_r == `AFM_WORD_BITS) begin
                word_valid_r <= 1'b1;
                word_r       <= shift_r;
            end
        end
    end
endmodule // afm_link_rx

// *** afm_regs.vh ***
// Summary of operation
// - Secure, alpha, hex vectors raise all-frame counter.
// - Alphanumeric vector after address adds one.
// - Normal decoding only when everything is clear.
// - Each all-frame frame ends with status.
// - Short instruction 001 with 000/010 assigns.
// - Code 000 carries address and frame.
// - Code 010 carries address, window, sequence.
// - Long-address 010 forwards following message word.
// - Every assignment raises its own counter.
// - Forward words, then status with frame number.
// - Sixteen temporary addresses, each own counter.
`ifndef AFM_REGS_VH
`define AFM_REGS_VH
`define AFM_OFF_CTRL     8'h00
`define AFM_OFF_PKT      8'h04
`define AFM_OFF_STAT     8'h08
`define AFM_OFF_PEND     8'h0c
`define AFM_OFF_ISTAT    8'h10
`define AFM_OFF_IMASK    8'h14
`define AFM_CTRL_FORCE_ALL_FRAME_BIT        0
`define AFM_PKT_DECREMENT_ALL_FRAME_BIT     0
`define AFM_PKT_DISABLE_TEMP_ADDRESS_BIT_LO 16
`define AFM_STAT_MODE    0
`define AFM_STAT_CNT_LO  8
`define AFM_STAT_FRM_LO  16
`define AFM_IRQ_ENTER    0
`define AFM_IRQ_LEAVE    1
`define AFM_IRQ_STATUS   2
`define AFM_IRQ_ASSIGN   3
`define AFM_IMASK_RST    4'h0
`define AFM_W_EOF        15
`define AFM_W_MSG        14
`define AFM_W_LONG       3
`define AFM_VT_SECURE    3'h0
`define AFM_VT_SHORT     3'h1
`define AFM_VT_ALPHA     3'h5
`define AFM_VT_HEX       3'h6
`define AFM_IC_FRAME     3'h0
`define AFM_IC_WINDOW    3'h2
`define AFM_WORD_BITS    5'h10
`define AFM_AFC_W        8
`define AFM_TAC_W        4
`endif

// *** afm_sat_counter.v ***
`timescale 1ns/10ps
module afm_sat_counter #(
    parameter W = 4
) (
    input  wire         hclk,
    input  wire         hresetn,
    input  wire         inc,
    input  wire         dec,
    output reg  [W-1:0] cnt_r,
    output wire         nz
);
    reg [W-1:0] cnt_nxt;

    assign nz = |cnt_r;

    // A raise and a lower in one cycle cancel; both ends saturate.
    always @* begin
        cnt_nxt = cnt_r;
        if (inc && !dec && !(&cnt_r)) begin
            cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
        end else if (dec && !inc && nz) begin
            cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= {W{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // afm_sat_counter

// *** afm_tracker.v ***
`timescale 1ns/10ps
`include "afm_regs.vh"
module afm_tracker (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        link_clk,
    input  wire        link_sync,
    input  wire        link_dat,
    output reg         all_frame_mode,
    output reg         status_valid,
    output reg         status_eof,
    output reg  [6:0]  status_frame,
    output reg         fwd_valid,
    output reg  [15:0] fwd_word,
    output reg         fwd_assign_frame,
    output wire        irq
);
    function is_off;
        input [7:0] a;
        input [7:0] off;
        begin
            is_off = (a == off);
        end
    endfunction

    wire        rx_valid;
    wire [15:0] rx_word;
    wire        w_eof;
    wire        w_msg;
    wire        w_vec;
    wire [2:0]  vtype;
    wire [2:0]  icode;
    wire [3:0]  taddr;
    wire        w_long;
    wire        afc_inc;
    wire        afc_dec;
    wire        ta_asg;
    wire [15:0] ta_inc;
    wire [15:0] ta_dec;
    wire [31:0] pkt_dis;
    wire [15:0] ta_nz;
    wire [63:0] ta_cnt;
    wire [7:0]  afc;
    wire        afc_nz;
    wire        mode_nxt;
    wire        ap_take;
    wire        wr_pkt;
    wire        wr_ctrl;
    wire        wr_mask;
    wire [3:0]  ev;
    wire [3:0]  istat_clr;
    wire [3:0]  istat_nxt;

    reg         force_all_frame_bit_r;
    reg  [3:0]  imask_r;
    reg  [3:0]  istat_r;
    reg         dp_wr_r;
    reg  [7:0]  dp_addr_r;
    reg         long_pend_r;
    reg  [6:0]  last_frame_r;

    afm_link_rx u_rx (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .link_clk     (link_clk),
        .link_sync    (link_sync),
        .link_dat     (link_dat),
        .word_valid_r (rx_valid),
        .word_r       (rx_word)
    );

    assign w_eof  = rx_word[`AFM_W_EOF];
    assign w_msg  = rx_word[`AFM_W_MSG] & ~w_eof;
    assign w_vec  = ~rx_word[`AFM_W_MSG] & ~w_eof;
    assign vtype  = rx_word[13:11];
    assign icode  = rx_word[10:8];
    assign taddr  = rx_word[7:4];
    assign w_long = rx_word[`AFM_W_LONG];

    // Alphanumeric, secure and hex vectors open a possibly fragmented message.
    assign afc_inc = rx_valid & w_vec & ((vtype == `AFM_VT_SECURE) |
                     (vtype == `AFM_VT_ALPHA) |
                     (vtype == `AFM_VT_HEX));

    // Both assignment codes count, so a doubly sent assignment counts twice.
    assign ta_asg = rx_valid & w_vec & (vtype == `AFM_VT_SHORT) &
                    ((icode == `AFM_IC_FRAME) |
                     (icode == `AFM_IC_WINDOW));

    // AHB-Lite slave: zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ap_take   = hsel & htrans[1] & hready;
    assign wr_pkt    = dp_wr_r & is_off(dp_addr_r, `AFM_OFF_PKT);
    assign wr_ctrl   = dp_wr_r & is_off(dp_addr_r, `AFM_OFF_CTRL);
    assign wr_mask   = dp_wr_r & is_off(dp_addr_r, `AFM_OFF_IMASK);

    // One packet write may lower the all-frame count and disable addresses.
    assign afc_dec = wr_pkt & hwdata[`AFM_PKT_DECREMENT_ALL_FRAME_BIT];
    assign pkt_dis = hwdata >> `AFM_PKT_DISABLE_TEMP_ADDRESS_BIT_LO;
    assign ta_dec  = wr_pkt ? pkt_dis[15:0] : 16'h0000;

    afm_sat_counter #(
        .W (`AFM_AFC_W)
    ) u_afc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .inc     (afc_inc),
        .dec     (afc_dec),
        .cnt_r   (afc),
        .nz      (afc_nz)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_ta
            assign ta_inc[gi] = ta_asg & ({28'h0000000, taddr} == gi);
            afm_sat_counter #(
                .W (`AFM_TAC_W)
            ) u_tac (
                .hclk    (hclk),
                .hresetn (hresetn),
                .inc     (ta_inc[gi]),
                .dec     (ta_dec[gi]),
                .cnt_r   (ta_cnt[4*gi+3:4*gi]),
                .nz      (ta_nz[gi])
            );
        end
    endgenerate

    // Normal decoding resumes only once every source of demand is gone.
    assign mode_nxt = afc_nz | (|ta_nz) | force_all_frame_bit_r;

    assign ev[`AFM_IRQ_ENTER]  = mode_nxt & ~all_frame_mode;
    assign ev[`AFM_IRQ_LEAVE]  = ~mode_nxt & all_frame_mode;
    assign ev[`AFM_IRQ_STATUS] = rx_valid & w_eof & all_frame_mode;
    assign ev[`AFM_IRQ_ASSIGN] = ta_asg;

    // A read of the interrupt status register clears it; a fresh event still wins.
    assign istat_clr = (ap_take & ~hwrite & is_off(haddr[7:0], `AFM_OFF_ISTAT)) ?
                       4'hf : 4'h0;
    assign istat_nxt = (istat_r & ~istat_clr) | ev;
    assign irq       = |(istat_r & imask_r);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata    <= 32'h00000000;
            force_all_frame_bit_r <= 1'b0;
            imask_r   <= `AFM_IMASK_RST;
            istat_r   <= 4'h0;
        end else begin
            dp_wr_r <= ap_take & hwrite;
            if (ap_take) begin
                dp_addr_r <= haddr[7:0];
            end
            if (ap_take && !hwrite) begin
                case (haddr[7:0])
                    `AFM_OFF_CTRL: begin
                        hrdata <= {31'h0, force_all_frame_bit_r};
                    end
                    `AFM_OFF_STAT: begin
                        hrdata <= {9'h0, last_frame_r, afc, 7'h0, all_frame_mode};
                    end
                    `AFM_OFF_PEND: begin
                        hrdata <= {16'h0, ta_nz};
                    end
                    `AFM_OFF_ISTAT: begin
                        hrdata <= {28'h0, istat_r};
                    end
                    `AFM_OFF_IMASK: begin
                        hrdata <= {28'h0, imask_r};
                    end
                    default: begin
                        hrdata <= 32'h00000000;
                    end
                endcase
            end
            if (wr_ctrl) begin
                force_all_frame_bit_r <= hwdata[`AFM_CTRL_FORCE_ALL_FRAME_BIT];
            end
            if (wr_mask) begin
                imask_r <= hwdata[3:0];
            end
            istat_r <= istat_nxt;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            all_frame_mode   <= 1'b0;
            status_valid     <= 1'b0;
            status_eof       <= 1'b0;
            status_frame     <= 7'h00;
            last_frame_r     <= 7'h00;
            fwd_valid        <= 1'b0;
            fwd_word         <= 16'h0000;
            fwd_assign_frame <= 1'b0;
            long_pend_r      <= 1'b0;
        end else begin
            all_frame_mode   <= mode_nxt;
            status_valid     <= 1'b0;
            fwd_valid        <= 1'b0;
            fwd_assign_frame <= 1'b0;
            if (rx_valid && !w_eof) begin
                fwd_valid <= 1'b1;
                fwd_word  <= rx_word;
            end
            // The word after a long-address window assignment holds its frame.
            if (ta_asg && icode == `AFM_IC_WINDOW && w_long) begin
                long_pend_r <= 1'b1;
            end else if (rx_valid && w_msg && long_pend_r) begin
                fwd_assign_frame <= 1'b1;
                long_pend_r      <= 1'b0;
            end else if (rx_valid && !w_msg) begin
                long_pend_r <= 1'b0;
            end
            if (rx_valid && w_eof) begin
                last_frame_r <= rx_word[6:0];
            end
            // Frame ends are reported only while every frame is decoded.
            if (rx_valid && w_eof && all_frame_mode) begin
                status_valid <= 1'b1;
                status_eof   <= 1'b1;
                status_frame <= rx_word[6:0];
            end
        end
    end
endmodule // afm_tracker

// *** afm_tracker_monitor.sv ***
`timescale 1ns/10ps
module afm_tracker_monitor (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire        link_sync,
    input wire        all_frame_mode,
    input wire        status_valid,
    input wire        status_eof,
    input wire        fwd_valid,
    input wire        fwd_assign_frame
);
    reg [3:0] lo_r;
    // Counts edges since the word strobe fell, so outputs can be tied to a finished word.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) lo_r <= 4'hf;
        else if (link_sync) lo_r <= 4'h0;
        else if (lo_r != 4'hf) lo_r <= lo_r + 4'h1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_ctrl_wr;
        hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
    endsequence
    sequence s_force_on;
        s_ctrl_wr ##1 hwdata[0];
    endsequence
    a_bus_okay: assert property (!hresp && hreadyout)
        else $error("bus answer not zero-wait OKAY");
    a_eof_flag: assert property (status_valid |-> status_eof)
        else $error("status without end of frame");
    a_status_mode: assert property (status_valid |-> $past(all_frame_mode))
        else $error("status outside all-frame decoding");
    a_assign_fwd: assert property (fwd_assign_frame |-> fwd_valid)
        else $error("assign-frame mark without word");
    a_fwd_single: assert property (fwd_valid |=> !fwd_valid)
        else $error("forward pulse too long");
    a_status_single: assert property (status_valid |=> !status_valid)
        else $error("status pulse too long");
    a_no_overlap: assert property (!(fwd_valid && status_valid))
        else $error("end of frame forwarded as word");
    a_word_latency: assert property ((fwd_valid || status_valid) |-> lo_r inside {[1:10]})
        else $error("output not tied to a finished word");
    a_force_enter: assert property (s_force_on |-> ##[1:3] all_frame_mode)
        else $error("force bit did not enter mode");
endmodule // afm_tracker_monitor

bind afm_tracker afm_tracker_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .link_sync(link_sync),
    .all_frame_mode(all_frame_mode), .status_valid(status_valid), .status_eof(status_eof),
    .fwd_valid(fwd_valid), .fwd_assign_frame(fwd_assign_frame));

// *** test_afm_tracker.sv ***
`timescale 1ns/10ps
module test_afm_tracker;
    reg         hclk = 1'h0;
    reg         hresetn = 1'h0;
    reg         hsel = 1'h0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'h0;
    reg  [31:0] hwdata = 32'h0;
    reg  [31:0] q;
    reg  [7:0]  rs = 8'h30;
    reg  [7:0]  n;
    reg  [7:0]  st_n = 8'h0;
    reg  [7:0]  af_n = 8'h0;
    reg  [6:0]  st_f = 7'h0;
    reg  [15:0] fw = 16'h0;
    reg  [3:0]  ta;
    wire        rdy, rsp, lck, lsy, ldt, afm, st_v, st_e, fv, fwa, irq;
    wire [31:0] hrdata;
    wire [6:0]  st_frm;
    wire [15:0] fw_w;
    integer     err_total = 0;
    integer     n_tests = 0;
    integer     k;
    initial forever #10 hclk = ~hclk;
    afm_link_model u_link (.link_clk(lck), .link_sync(lsy), .link_dat(ldt));
    afm_tracker dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
        .hreadyout(rdy), .hresp(rsp), .hrdata(hrdata), .link_clk(lck), .link_sync(lsy),
        .link_dat(ldt), .all_frame_mode(afm), .status_valid(st_v), .status_eof(st_e),
        .status_frame(st_frm), .fwd_valid(fv), .fwd_word(fw_w), .fwd_assign_frame(fwa),
        .irq(irq));
    always @(posedge hclk) begin
        if (st_v) st_n <= st_n + 8'h1;
        if (st_v) st_f <= st_frm;
        if (fv) fw <= fw_w;
        if (fv & fwa) af_n <= af_n + 8'h1;
    end
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function [15:0] vec(input [2:0] vt, input [2:0] ic, input [3:0] t, input lg);
        vec = {2'h0, vt, ic, t, lg, 3'h0};
    endfunction
    function [31:0] stat(input m, input [7:0] c, input [6:0] f);
        stat = {9'h0, f, c, 7'h0, m};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task ahb(input w, input [7:0] a, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (rdy !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (rdy !== 1'h1) @(posedge hclk);
        q = hrdata;
        repeat (2) @(posedge hclk);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        ahb(1'h0, a, 32'h0);
        chk(q, e);
    endtask
    task lnk(input [15:0] w);
        u_link.send(w);
        repeat (12) @(posedge hclk);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total = err_total + 1;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (4) @(posedge hclk);
        rd(8'h00, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h30, 32'h0);
        for (n = 8'h0; n < 8'h3; n = n + 8'h1) begin
            lnk(vec(n == 8'h0 ? 3'h5 : n == 8'h1 ? 3'h0 : 3'h6, 3'h0, 4'h0, 1'h0));
            rd(8'h08, stat(1'h1, n + 8'h1, 7'h0));
        end
        chk(irq, 1'h0);
        ahb(1'h1, 8'h14, 32'h1);
        chk(irq, 1'h1);
        rd(8'h10, 32'h1);
        chk(irq, 1'h0);
        rs = lfsr(rs);
        lnk({9'h100, rs[6:0]});
        chk(st_n, 8'h1);
        chk(st_f, rs[6:0]);
        lnk({2'h1, rs, 6'h2a});
        chk(fw, {2'h1, rs, 6'h2a});
        for (n = 8'h3; n > 8'h0; n = n - 8'h1) begin
            ahb(1'h1, 8'h04, 32'h1);
            rd(8'h08, stat(n != 8'h1, n - 8'h1, rs[6:0]));
        end
        ahb(1'h1, 8'h04, 32'h1);
        rd(8'h08, stat(1'h0, 8'h0, rs[6:0]));
        lnk(16'h8005);
        chk(st_n, 8'h1);
        rd(8'h10, 32'h6);
        $display("all-frame counter test done");
        for (k = 0; k < 2; k = k + 1) begin
            rs = lfsr(rs);
            ta = rs[3:0];
            lnk(vec(3'h1, 3'h0, ta, 1'h0));
            lnk(vec(3'h1, 3'h1, ta + 4'h1, 1'h0));
            lnk(vec(3'h1, 3'h2, ta, 1'h1));
            lnk({2'h1, 14'h0123});
            chk(af_n, k + 1);
            lnk({9'h100, rs[6:0]});
            chk(st_n, k + 2);
            chk(st_f, rs[6:0]);
            chk(afm, 1'h1);
            rd(8'h0c, 32'h1 << ta);
            ahb(1'h1, 8'h04, 32'h10000 << ta);
            rd(8'h0c, 32'h1 << ta);
            lnk(vec(3'h5, 3'h0, 4'h0, 1'h0));
            ahb(1'h1, 8'h04, (32'h10000 << ta) | 32'h1);
            rd(8'h0c, 32'h0);
            chk(afm, 1'h0);
            ahb(1'h1, 8'h04, 32'h10000 << ta);
            rd(8'h0c, 32'h0);
        end
        chk(irq, 1'h1);
        rd(8'h10, 32'hf);
        chk(irq, 1'h0);
        $display("temporary address test done");
        ahb(1'h1, 8'h00, 32'h1);
        chk(afm, 1'h1);
        rd(8'h00, 32'h1);
        ahb(1'h1, 8'h00, 32'h0);
        chk(afm, 1'h0);
        $display("force bit test done");
        report_and_stop;
    end
endmodule // test_afm_tracker
